// [hw/conn_defines.svh]
`ifndef CONN_DEFINES_SVH
`define CONN_DEFINES_SVH

// transceiver skew before releasing inverse address acknowledge
`define SKEW_NS 50
`define CLK_PERIOD_NS 25
`define SKEW_CYCLES ((`SKEW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// interrupt status bit positions
`define EV_CONNECT 0
`define EV_ERROR 1
`define EV_ABORT 2
`define EV_COUNT 3

// register indices on the local port
`define REG_STATUS 4'h0
`define REG_CLEAR 4'h1
`define REG_ENABLE 4'h2
`define REG_BASE 4'h3
`define REG_MASK 4'h4
`define REG_PHASE 4'h5
`define REG_BCAST 4'h6
`define REG_BCMASK 4'h7

// command codes: bit0 write, bit1 unsupported
`define CMD_WIDTH 4

`endif

// [hw/conn_pkg.sv]
package conn_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ACK = 3'b001,
        ST_SKEW = 3'b010,
        ST_WAIT_MEM = 3'b011,
        ST_DATA = 3'b100,
        ST_DISC = 3'b101,
        ST_UNSEL = 3'b110
    } phase_t;
endpackage

// [hw/backplane_slave_connection.sv]
// Function
// - access runs connection, then data, then disconnection phase.
// - beat parity follows handshake only; bank picked by low double-word address bit.
// - on address sync seen, assert address acknowledge.
// - latch and decode address at address sync, making board select.
// - unselected board only asserts inverse ack and drops ack at disconnect.
// - selected board decodes command and drives status and capability.
// - assert selected status whenever selected.
// - assert broadcast status for shared regions such as register space.
// - assert beat error for unsupported command or address/command parity error.
// - keep split response released, assert compelled capability.
// - assert inverse data acknowledge during connection phase.
// - after skew delay release inverse address acknowledge.
// - start memory access; memory answers with address ready.
// - no odd beat entry until address ready, despite early data sync.
// - address sync lost before data beat goes straight to disconnection.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "conn_defines.svh"

module backplane_slave_connection
    import conn_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int SKEW_CYC = `SKEW_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic as_i,
    input wire logic ds_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [`CMD_WIDTH-1:0] cmd_i,
    input wire logic par_err_i,
    output logic ak_o,
    output logic ai_o,
    output logic di_o,
    output logic sl_o,
    output logic bc_o,
    output logic be_o,
    output logic sr_o,
    output logic co_o,
    output logic mem_req_o,
    output logic mem_wr_o,
    output logic bank_o,
    input wire logic addr_ack_i,
    output logic data_phase_o,
    output logic disc_o,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic irq_o
);

    typedef struct packed {
        phase_t phase;
        logic [7:0] skew;
        logic [ADDR_W-1:0] addr;
        logic [`CMD_WIDTH-1:0] cmd;
        logic sel;
        logic ak;
        logic ai;
        logic di;
        logic sl;
        logic bc;
        logic be;
        logic perr;
        logic sr;
        logic co;
        logic mreq;
        logic data;
        logic disc;
        logic [`EV_COUNT-1:0] stat;
        logic [`EV_COUNT-1:0] en;
        logic [ADDR_W-1:0] base;
        logic [ADDR_W-1:0] mask;
        logic [ADDR_W-1:0] bcbase;
        logic [ADDR_W-1:0] bcmask;
        logic [31:0] rdata;
        logic irq;
    } state_t;

    state_t q, d;
    logic hit, bhit;
    logic [`EV_COUNT-1:0] ev;
    logic as_sync;
    logic ds_sync;
    logic ack_sync;
    logic perr_sync;
    logic [ADDR_W-1:0] addr_sync;
    logic [`CMD_WIDTH-1:0] cmd_sync;

    sync_stages #(
        .W(1)
    ) as_stages (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(as_i),
        .sync_o(as_sync)
    );

    sync_stages #(
        .W(1)
    ) ds_stages (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ds_i),
        .sync_o(ds_sync)
    );

    sync_stages #(
        .W(1)
    ) ack_stages (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(addr_ack_i),
        .sync_o(ack_sync)
    );

    sync_stages #(
        .W(1)
    ) perr_stages (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(par_err_i),
        .sync_o(perr_sync)
    );

    // stage address bus
    // bus settles before address sync is seen, so plain staging cannot tear it
    sync_stages #(
        .W(ADDR_W)
    ) addr_stages (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(addr_i),
        .sync_o(addr_sync)
    );

    sync_stages #(
        .W(`CMD_WIDTH)
    ) cmd_stages (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(cmd_i),
        .sync_o(cmd_sync)
    );

    always_comb begin
        d = q;
        ev = '0;
        d.sr = 1'b0;
        hit = ((q.addr & q.mask) == (q.base & q.mask));
        bhit = ((q.addr & q.bcmask) == (q.bcbase & q.bcmask));
        case (q.phase)
            ST_IDLE: begin
                d.ai = 1'b1;
                if (as_sync) begin
                    d.ak = 1'b1;
                    // latch address, command is stable by now
                    d.addr = addr_sync;
                    d.cmd = cmd_sync;
                    d.perr = perr_sync;
                    d.phase = ST_ACK;
                end
            end
            ST_ACK: begin
                d.sel = hit | bhit;
                if (hit | bhit) begin
                    d.sl = 1'b1;
                    d.bc = bhit;
                    d.be = q.perr | q.cmd[1];
                    d.co = 1'b1;
                    d.di = 1'b1;
                    d.mreq = 1'b1;
                    if (q.perr | q.cmd[1]) begin
                        ev[`EV_ERROR] = 1'b1;
                    end
                    d.skew = 8'(SKEW_CYC);
                    d.phase = ST_SKEW;
                end else begin
                    d.phase = ST_UNSEL;
                end
            end
            ST_SKEW: begin
                if (q.skew > 8'h01) begin
                    d.skew = q.skew - 8'h01;
                end else begin
                    d.ai = 1'b0;
                    ev[`EV_CONNECT] = 1'b1;
                    d.phase = ST_WAIT_MEM;
                end
                if (!as_sync) begin
                    d.phase = ST_DISC;
                    ev[`EV_ABORT] = 1'b1;
                end
            end
            ST_WAIT_MEM: begin
                if (!as_sync) begin
                    d.phase = ST_DISC;
                    ev[`EV_ABORT] = 1'b1;
                end else if (ack_sync && ds_sync) begin
                    d.data = 1'b1;
                    d.phase = ST_DATA;
                end
            end
            ST_DATA: begin
                if (!as_sync) begin
                    d.phase = ST_DISC;
                end
            end
            ST_UNSEL: begin
                if (!as_sync) begin
                    d.phase = ST_DISC;
                end
            end
            ST_DISC: begin
                d.ai = 1'b1;
                d.ak = 1'b0;
                d.sl = 1'b0;
                d.bc = 1'b0;
                d.be = 1'b0;
                d.co = 1'b0;
                d.di = 1'b0;
                d.mreq = 1'b0;
                d.data = 1'b0;
                d.sel = 1'b0;
                d.phase = ST_IDLE;
            end
            default: begin
                d.phase = ST_IDLE;
            end
        endcase
        d.disc = (d.phase == ST_DISC);
        d.rdata = 32'h0000_0000;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `REG_CLEAR: d.stat = q.stat & ~reg_wdata_i[`EV_COUNT-1:0];
                `REG_ENABLE: d.en = reg_wdata_i[`EV_COUNT-1:0];
                `REG_BASE: d.base = reg_wdata_i[ADDR_W-1:0];
                `REG_MASK: d.mask = reg_wdata_i[ADDR_W-1:0];
                `REG_BCAST: d.bcbase = reg_wdata_i[ADDR_W-1:0];
                `REG_BCMASK: d.bcmask = reg_wdata_i[ADDR_W-1:0];
                default: begin
                end
            endcase
        end
        // set wins over clear
        d.stat = d.stat | ev;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `REG_STATUS: d.rdata = 32'(q.stat);
                `REG_ENABLE: d.rdata = 32'(q.en);
                `REG_BASE: d.rdata = 32'(q.base);
                `REG_MASK: d.rdata = 32'(q.mask);
                `REG_PHASE: d.rdata = {27'h0, q.sel, q.data, q.phase};
                `REG_BCAST: d.rdata = 32'(q.bcbase);
                `REG_BCMASK: d.rdata = 32'(q.bcmask);
                default: d.rdata = 32'h0000_0000;
            endcase
        end
        d.irq = |(d.stat & d.en);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.ai <= 1'b1;
            q.mask <= {ADDR_W{1'b1}};
            q.bcmask <= {ADDR_W{1'b1}};
            q.bcbase <= {ADDR_W{1'b1}};
        end else begin
            q <= d;
        end
    end

    assign ak_o = q.ak;
    assign ai_o = q.ai;
    assign di_o = q.di;
    assign sl_o = q.sl;
    assign bc_o = q.bc;
    assign be_o = q.be;
    assign sr_o = q.sr;
    assign co_o = q.co;
    assign mem_req_o = q.mreq;
    assign mem_wr_o = q.cmd[0];
    assign bank_o = q.addr[3];
    assign data_phase_o = q.data;
    assign disc_o = q.disc;
    assign reg_rdata_o = q.rdata;
    assign irq_o = q.irq;

endmodule

module sync_stages
    import conn_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } stages_t;

    stages_t q, d;

    // only the second stage feeds logic, keeping metastability out
    always_comb begin
        d = q;
        d.first = pin_i;
        d.second = q.first;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.second;

endmodule

// [bench/mem_ctl_model.sv]
`timescale 1ns/1ps
module mem_ctl_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mem_req_i,
    input wire logic slow_i,
    output logic addr_ack_o
);
    logic [4:0] cnt_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || !mem_req_i) begin
            cnt_q <= 5'h00;
            addr_ack_o <= 1'b0;
        end else if (cnt_q == (slow_i ? 5'h14 : 5'h02)) begin
            addr_ack_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
endmodule

// [bench/backplane_slave_connection_properties.sv]
`timescale 1ns/1ps
module conn_props #(
    parameter int SKEW_CYC = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic as_i,
    input wire logic ds_i,
    input wire logic addr_ack_i,
    input wire logic ak_o,
    input wire logic ai_o,
    input wire logic di_o,
    input wire logic sl_o,
    input wire logic be_o,
    input wire logic sr_o,
    input wire logic co_o,
    input wire logic mem_req_o,
    input wire logic data_phase_o,
    input wire logic disc_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_on_sync: assert property ($rose(as_i) |-> ##[1:4] ak_o)
        else $error("ack late");
    a_split_released: assert property (!sr_o)
        else $error("split driven");
    a_compelled_sel: assert property (sl_o |-> co_o)
        else $error("compelled missing");
    a_di_on_select: assert property ($rose(sl_o) |-> di_o && mem_req_o)
        else $error("di or request missing");
    a_err_needs_sel: assert property (be_o |-> sl_o)
        else $error("beat error unselected");
    a_unsel_quiet: assert property (!sl_o |-> !di_o && !mem_req_o && !data_phase_o)
        else $error("unselected board active");
    a_skew_release: assert property ($rose(sl_o) |-> ##SKEW_CYC $fell(ai_o))
        else $error("ai release timing");
    a_data_after_ack: assert property ($rose(data_phase_o) |-> $past(addr_ack_i) && $past(ds_i) && !ai_o)
        else $error("early data phase");
    a_abort_disc: assert property ($fell(as_i) && sl_o && !data_phase_o |-> ##[1:5] disc_o)
        else $error("no disconnect");
    c_data: cover property ($rose(data_phase_o));
    c_err: cover property ($rose(be_o));
    c_disc: cover property ($rose(disc_o));
endmodule
bind backplane_slave_connection conn_props #(.SKEW_CYC(SKEW_CYC)) u_props (
    .clk_i, .rst_i, .as_i, .ds_i, .addr_ack_i, .ak_o, .ai_o, .di_o, .sl_o, .be_o,
    .sr_o, .co_o, .mem_req_o, .data_phase_o, .disc_o
);

// [bench/backplane_slave_connection_tb_top.sv]
`timescale 1ns/1ps
module backplane_slave_connection_tb_top;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic clk_i = 1'b0, rst_i = 1'b1, as_i = 1'b0, ds_i = 1'b0, par_err_i = 1'b0, slow_mem = 1'b1;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, addr_ack_i, ak_o, ai_o, di_o, sl_o, bc_o, be_o, sr_o, co_o;
    logic mem_req_o, mem_wr_o, bank_o, data_phase_o, disc_o, irq_o;
    logic [31:0] addr_i = 32'h0, reg_wdata_i = 32'h0, reg_rdata_o;
    logic [3:0] cmd_i = 4'h0, reg_addr_i = 4'h0;
    int error_cnt = 0, total_checks = 0;
    always #12.5 clk_i = ~clk_i;
    backplane_slave_connection dut (.clk_i, .rst_i, .as_i, .ds_i, .addr_i, .cmd_i, .par_err_i, .ak_o,
        .ai_o, .di_o, .sl_o, .bc_o, .be_o, .sr_o, .co_o, .mem_req_o, .mem_wr_o, .bank_o, .addr_ack_i,
        .data_phase_o, .disc_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);
    mem_ctl_model mem (.clk_i, .rst_i, .mem_req_i(mem_req_o), .slow_i(slow_mem), .addr_ack_o(addr_ack_i));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o & m, e);
    endtask
    task start(input logic [31:0] a, input logic [3:0] c, input logic pe, input logic d);
        @(posedge clk_i);
        addr_i <= a;
        cmd_i <= c;
        par_err_i <= pe;
        @(posedge clk_i);
        as_i <= 1'b1;
        ds_i <= d;
        repeat (5) @(posedge clk_i);
        #1 chk(ak_o, 1'b1);
    endtask
    // released bus shows inverted address, not a stale copy
    task fin;
        @(posedge clk_i);
        as_i <= 1'b0;
        ds_i <= 1'b0;
        addr_i <= ~addr_i;
        repeat (3) @(posedge clk_i);
        #1 chk(disc_o, 1'b1);
        repeat (3) @(posedge clk_i);
        #1 chk({ai_o, sl_o, ak_o, mem_req_o}, 4'h8);
    endtask
    task results;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_i);
        error_cnt++;
        results();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 chk({ai_o, ak_o, sl_o, di_o}, 4'h8);
        rd(4'h4, ALL, ALL);
        rd(4'h6, ALL, ALL);
        rd(4'h7, ALL, ALL);
        wr(4'h8, 32'h0000_0055);
        rd(4'h8, ALL, 32'h0);
        wr(4'h3, 32'h0000_1000);
        wr(4'h4, 32'hFFFF_F000);
        wr(4'h6, 32'h0000_3000);
        wr(4'h7, 32'hFFFF_F000);
        wr(4'h2, 32'h0000_0007);
        start(32'h0000_1008, 4'h1, 1'b0, 1'b1);
        chk({sl_o, co_o, di_o, sr_o, bc_o, be_o}, 32'h38);
        chk({mem_req_o, mem_wr_o, bank_o}, 32'h7);
        repeat (6) @(posedge clk_i);
        #1 chk({ai_o, data_phase_o}, 32'h0);
        repeat (25) @(posedge clk_i);
        #1 chk(data_phase_o, 1'b1);
        rd(4'h5, ALL, 32'h0000_001C);
        fin();
        rd(4'h0, 32'h1, 32'h1);
        chk(irq_o, 1'b1);
        slow_mem <= 1'b0;
        start(32'h0000_1000, 4'h0, 1'b0, 1'b1);
        repeat (8) @(posedge clk_i);
        #1 chk({mem_wr_o, bank_o, data_phase_o}, 32'h1);
        fin();
        start(32'h0000_2000, 4'h1, 1'b0, 1'b1);
        chk({sl_o, di_o, mem_req_o, ai_o, data_phase_o}, 32'h2);
        fin();
        start(32'h0000_3010, 4'h0, 1'b0, 1'b0);
        chk({bc_o, sl_o}, 32'h3);
        fin();
        for (int i = 0; i < 2; i++) begin
            wr(4'h1, 32'h0000_0007);
            start(32'h0000_1000, (i == 0) ? 4'h2 : 4'h0, i[0], 1'b0);
            chk({be_o, sl_o}, 32'h3);
            fin();
            rd(4'h0, 32'h6, 32'h6);
        end
        chk(irq_o, 1'b1);
        wr(4'h2, 32'h0);
        repeat (2) @(posedge clk_i);
        #1 chk(irq_o, 1'b0);
        wr(4'h1, 32'h0000_0007);
        rd(4'h0, ALL, 32'h0);
        results();
    end
endmodule
